//--- src/fsag_guard.sv
// Flash section access guard with AXI4-Lite control registers
// Overview of operation
// - Flash splits into application and boot regions by fuse, each own lock
// - Store-program from application region never starts anything
// - Store-program works only from boot region, may target whole flash
// - Programming class follows target page address, not fetch address
// - Programming read-while region keeps CPU running, stall region readable
// - Programming stall region halts CPU until operation ends
// - Boot region always lies inside stall region
// - Busy flag reads one while read-while region is blocked
// - Boot lock bits only programmable by software, cleared by chip erase
// - General lock modes never gate store-program or load-program
// - Application lock field gates writes and boot-code loads
// - Application lock suppresses interrupts in application with boot vectors
// - Boot lock field gates writes and application-code loads
// - Boot lock suppresses interrupts in boot with application vectors
// - Busy flag set on read-while erase or write, cleared by buffer load
// - Re-enable command within four cycles clears busy flag
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`include "fsag_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fsag_guard (
   input  wire  logic                clk,
   input  wire  logic                rstn,
   input  wire  logic                ce,
   input  wire  logic [1:0]          bootSizeFuse,
   input  wire  logic                chipErase,
   input  wire  logic [11:0]         execAddr,
   input  wire  logic                spmReq,
   input  wire  logic [11:0]         spmAddr,
   input  wire  logic [7:0]          spmData,
   input  wire  logic                lpmReq,
   input  wire  logic [11:0]         lpmAddr,
   input  wire  logic                progDone,
   output logic                      spmAck_q,
   output logic                      spmNack_q,
   output logic                      lpmOk_q,
   output logic                      lpmDenied_q,
   output logic                      cpuHalt_q,
   output logic                      rwwBusy_q,
   output logic                      fetchBlock_q,
   output logic                      irqSuppress_q,
   output logic                      flashStart_q,
   output fsag_pkg::fsag_op_t        flashOp_q,
   output logic [11:0]               flashPage_q,
   input  wire  logic [7:0]          s_axi_awaddr,
   input  wire  logic                s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire  logic [31:0]         s_axi_wdata,
   input  wire  logic [3:0]          s_axi_wstrb,
   input  wire  logic                s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire  logic                s_axi_bready,
   input  wire  logic [7:0]          s_axi_araddr,
   input  wire  logic                s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire  logic                s_axi_rready
);
   import fsag_pkg::*;

   function automatic logic inBoot(input logic [11:0] a,
                                   input logic [11:0] start);
      inBoot = (a >= start);
   endfunction : inBoot

   fsag_state_t  state_q;
   fsag_op_t     op_q;
   logic [1:0]   armCnt_q;
   logic [3:0]   lock_q;
   logic         vecInBoot_q;
   logic [11:0]  bootStart_q;
   logic [1:0]   fuseMeta_q;
   logic [1:0]   fuse_q;
   logic         eraseMeta_q;
   logic         erase_q;
   logic         awHeld_q;
   logic         wHeld_q;
   logic [7:0]   awAddr_q;
   logic [31:0]  wData_q;
   logic [3:0]   wStrb_q;
   logic         doWrite;
   logic         wrCtrl;
   logic         wrLock;
   logic         fromBoot;
   logic         tgtBoot;
   logic         tgtRww;
   logic         writeOk;
   logic         spmTake;
   logic         start;
   logic         accept;
   fsag_op_t     cmdOp;
   logic [11:0]  bootTable;

   // Lock bits {boot2, boot1, app2, app1}; one means unprogrammed
   assign fromBoot = inBoot(execAddr, bootStart_q);
   assign tgtBoot  = inBoot(spmAddr, bootStart_q);
   assign tgtRww   = spmAddr < `FSAG_RWW_LIMIT;
   assign writeOk  = fromBoot && (tgtBoot ? lock_q[2] : lock_q[0]);
   assign spmTake  = ce && spmReq && state_q == ST_ARMED;
   assign start    = spmTake && writeOk
                     && (op_q == OP_ERASE || op_q == OP_WRITE);
   // Non-programming commands only need boot-region execution
   assign accept   = start || (spmTake && fromBoot
                     && (op_q == OP_LOAD || op_q == OP_LOCK
                         || op_q == OP_REEN));

   always_comb begin
      // Decode the captured word; the bus may drop wdata once it is taken
      case (wData_q[4:0])
         `FSAG_CMD_LOAD:  cmdOp = OP_LOAD;
         `FSAG_CMD_ERASE: cmdOp = OP_ERASE;
         `FSAG_CMD_WRITE: cmdOp = OP_WRITE;
         `FSAG_CMD_LOCK:  cmdOp = OP_LOCK;
         `FSAG_CMD_REEN:  cmdOp = OP_REEN;
         default:         cmdOp = OP_NONE;
      endcase
      case (fuse_q)
         2'h0:    bootTable = `FSAG_BOOT_SZ0;
         2'h1:    bootTable = `FSAG_BOOT_SZ1;
         2'h2:    bootTable = `FSAG_BOOT_SZ2;
         default: bootTable = `FSAG_BOOT_SZ3;
      endcase
   end

   assign doWrite = ce && awHeld_q && wHeld_q && !s_axi_bvalid;
   // Commands written while a page operation runs are dropped
   assign wrCtrl  = doWrite && awAddr_q == `FSAG_CTRL_OFS && wStrb_q[0]
                    && state_q != ST_PROG;
   assign wrLock  = doWrite && awAddr_q == `FSAG_LOCK_OFS && wStrb_q[0];

   // Pin synchronisers for fuse and chip erase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fuseMeta_q  <= 2'h0;
         fuse_q      <= 2'h0;
         eraseMeta_q <= 1'b0;
         erase_q     <= 1'b0;
         bootStart_q <= `FSAG_RWW_LIMIT;
      end else if (ce) begin
         fuseMeta_q  <= bootSizeFuse;
         fuse_q      <= fuseMeta_q;
         eraseMeta_q <= chipErase;
         erase_q     <= eraseMeta_q;
         // Clamp keeps boot code clear of the read-while region
         bootStart_q <= (bootTable < `FSAG_RWW_LIMIT) ?
                        `FSAG_RWW_LIMIT : bootTable;
      end
   end

   // Command sequencer: arm window then page operation
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q  <= ST_IDLE;
         op_q     <= OP_NONE;
         armCnt_q <= 2'h0;
      end else if (ce) begin
         case (state_q)
            ST_IDLE: begin
               if (wrCtrl && cmdOp != OP_NONE) begin
                  state_q  <= ST_ARMED;
                  op_q     <= cmdOp;
                  armCnt_q <= 2'h0;
               end
            end
            ST_ARMED: begin
               armCnt_q <= armCnt_q + 2'h1;
               if (start) begin
                  state_q <= ST_PROG;
               end else if (spmReq || armCnt_q == `FSAG_ARM_LAST) begin
                  state_q <= ST_IDLE;
                  op_q    <= OP_NONE;
               end
            end
            default: begin
               if (progDone) begin
                  state_q <= ST_IDLE;
                  op_q    <= OP_NONE;
               end
            end
         endcase
      end
   end

   // Busy flag: set by read-while page operation, cleared by load or re-enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rwwBusy_q <= 1'b0;
      end else if (ce) begin
         if (start && tgtRww) begin
            rwwBusy_q <= 1'b1;
         end else if (accept && (op_q == OP_LOAD || op_q == OP_REEN)) begin
            rwwBusy_q <= 1'b0;
         end
      end
   end

   // CPU halt only for stall-region targets
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpuHalt_q <= 1'b0;
      end else if (ce) begin
         if (start && !tgtRww) begin
            cpuHalt_q <= 1'b1;
         end else if (state_q == ST_PROG && progDone) begin
            cpuHalt_q <= 1'b0;
         end
      end
   end

   // Lock bits only ever move toward programmed; chip erase restores
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_q      <= `FSAG_LOCK_RST;
         vecInBoot_q <= 1'b0;
      end else if (ce) begin
         if (erase_q) begin
            lock_q <= `FSAG_LOCK_RST;
         end else if (accept && op_q == OP_LOCK) begin
            lock_q <= lock_q & spmData[5:2];
         end else if (wrLock) begin
            lock_q <= lock_q & wData_q[3:0];
         end
         if (doWrite && awAddr_q == `FSAG_CONF_OFS && wStrb_q[0]) begin
            vecInBoot_q <= wData_q[0];
         end
      end
   end

   // CPU-facing answers and flash macro commands
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         spmAck_q      <= 1'b0;
         spmNack_q     <= 1'b0;
         lpmOk_q       <= 1'b0;
         lpmDenied_q   <= 1'b0;
         fetchBlock_q  <= 1'b0;
         irqSuppress_q <= 1'b0;
         flashStart_q  <= 1'b0;
         flashOp_q     <= OP_NONE;
         flashPage_q   <= 12'h000;
      end else if (ce) begin
         spmAck_q     <= accept;
         spmNack_q    <= spmReq && !accept;
         flashStart_q <= accept;
         if (accept) begin
            flashOp_q   <= op_q;
            flashPage_q <= spmAddr;
         end
         // General lock modes take no part here
         lpmOk_q <= lpmReq
            && !(rwwBusy_q && lpmAddr < `FSAG_RWW_LIMIT)
            && !(fromBoot && !inBoot(lpmAddr, bootStart_q) && !lock_q[1])
            && !(!fromBoot && inBoot(lpmAddr, bootStart_q) && !lock_q[3]);
         lpmDenied_q <= lpmReq
            && ((rwwBusy_q && lpmAddr < `FSAG_RWW_LIMIT)
            || (fromBoot && !inBoot(lpmAddr, bootStart_q) && !lock_q[1])
            || (!fromBoot && inBoot(lpmAddr, bootStart_q) && !lock_q[3]));
         fetchBlock_q <= rwwBusy_q && execAddr < `FSAG_RWW_LIMIT;
         irqSuppress_q <= (!lock_q[1] && vecInBoot_q && !fromBoot)
                       || (!lock_q[3] && !vecInBoot_q && fromBoot);
      end
   end

   // AXI4-Lite write side; one write in flight, address and data any order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FSAG_RESP_OK;
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 8'h00;
         wData_q       <= 32'h0000_0000;
         wStrb_q       <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q      <= 1'b1;
            awAddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q      <= 1'b1;
            wData_q      <= s_axi_wdata;
            wStrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == `FSAG_CTRL_OFS
               || awAddr_q == `FSAG_LOCK_OFS || awAddr_q == `FSAG_CONF_OFS
               || awAddr_q == `FSAG_STAT_OFS) ? `FSAG_RESP_OK
                                              : `FSAG_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read side
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `FSAG_RESP_OK;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `FSAG_RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr == `FSAG_CTRL_OFS) begin
               s_axi_rdata[`FSAG_BUSY_BIT] <= rwwBusy_q;
               s_axi_rdata[0] <= state_q != ST_IDLE;
            end else if (s_axi_araddr == `FSAG_LOCK_OFS) begin
               s_axi_rdata[3:0] <= lock_q;
            end else if (s_axi_araddr == `FSAG_CONF_OFS) begin
               s_axi_rdata[0] <= vecInBoot_q;
            end else if (s_axi_araddr == `FSAG_STAT_OFS) begin
               s_axi_rdata[13:0] <= {bootStart_q, cpuHalt_q,
                                     state_q == ST_PROG};
            end else begin
               s_axi_rresp <= `FSAG_RESP_ERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   noAppSpm_a: assert property (spmTake && !fromBoot |=> !spmAck_q)
      else $error("store-program accepted from application region");
   bootInStall_a: assert property (bootStart_q >= `FSAG_RWW_LIMIT)
      else $error("boot region reaches read-while region");
   stallHalt_a: assert property (start && !tgtRww |=> cpuHalt_q)
      else $error("stall-region programming did not halt CPU");
   rwwBusySet_a: assert property (start && tgtRww |=> rwwBusy_q && !cpuHalt_q)
      else $error("read-while programming did not set busy only");
   rwwLpmBlock_a: assert property (ce && lpmReq && rwwBusy_q
      && lpmAddr < `FSAG_RWW_LIMIT |=> lpmDenied_q && !lpmOk_q)
      else $error("load from blocked region allowed");
   armWindow_a: assert property (ce && state_q == ST_ARMED && !spmReq
      && armCnt_q == `FSAG_ARM_LAST |=> state_q == ST_IDLE)
      else $error("arm window outlived four cycles");
   lockSticky_a: assert property (!erase_q |=> (lock_q & ~$past(lock_q)) == 4'h0)
      else $error("lock bit returned to unprogrammed without erase");
   appLoadLock_a: assert property (ce && lpmReq && fromBoot && !lock_q[1]
      && !inBoot(lpmAddr, bootStart_q) |=> lpmDenied_q)
      else $error("boot load from locked application allowed");
   irqGate_a: assert property (ce && !lock_q[3] && !vecInBoot_q && fromBoot
      |=> irqSuppress_q)
      else $error("interrupts not suppressed in boot region");

   progRww_c: cover property (start && tgtRww ##[1:20] accept);
   progStall_c: cover property (start && !tgtRww ##[1:20] !cpuHalt_q);
   armTimeout_c: cover property (state_q == ST_ARMED ##4 state_q == ST_IDLE);
endmodule : fsag_guard
`default_nettype wire

//--- src/fsag_cfg.svh
// Register offsets, field positions, reset values and counts of the guard
`ifndef FSAG_CFG_SVH
`define FSAG_CFG_SVH
`define FSAG_CTRL_OFS  8'h00
`define FSAG_LOCK_OFS  8'h04
`define FSAG_CONF_OFS  8'h08
`define FSAG_STAT_OFS  8'h0C
`define FSAG_BUSY_BIT  6
`define FSAG_LOCK_RST  4'hF
`define FSAG_ARM_LAST  2'h3
`define FSAG_RWW_LIMIT 12'hC00
`define FSAG_BOOT_SZ0  12'hC00
`define FSAG_BOOT_SZ1  12'hE00
`define FSAG_BOOT_SZ2  12'hF00
`define FSAG_BOOT_SZ3  12'hF80
`define FSAG_CMD_LOAD  5'h01
`define FSAG_CMD_ERASE 5'h03
`define FSAG_CMD_WRITE 5'h05
`define FSAG_CMD_LOCK  5'h09
`define FSAG_CMD_REEN  5'h11
`define FSAG_RESP_OK   2'h0
`define FSAG_RESP_ERR  2'h2
`endif

//--- src/fsag_pkg.sv
// Types shared by the flash section access guard
package fsag_pkg;
   typedef enum {ST_IDLE, ST_ARMED, ST_PROG} fsag_state_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_LOAD, OP_ERASE, OP_WRITE, OP_LOCK, OP_REEN
   } fsag_op_t;
endpackage : fsag_pkg

//--- verif/fsag_cpu_model.sv
// CPU core model issuing store-program and load-program requests
`timescale 1ns/1ps
`default_nettype none
module fsag_cpu_model (
   input  wire  logic        clk,
   input  wire  logic        cpuHalt,
   input  wire  logic        rwwBusy,
   output logic [11:0]       execAddr,
   output logic              spmReq,
   output logic [11:0]       spmAddr,
   output logic [7:0]        spmData,
   output logic              lpmReq,
   output logic [11:0]       lpmAddr
);
   initial begin
      execAddr = 12'hC80;
      {spmReq, lpmReq, spmAddr, lpmAddr, spmData} = '0;
   end

   task automatic goExec(input logic [11:0] a);
      int n;
      // Stays out of the read-while region until its flag drops
      for (n = 0; n < 500 && rwwBusy && a < 12'hC00; n++) @(posedge clk);
      @(posedge clk);
      execAddr <= a;
   endtask : goExec

   task automatic store_program_op(input logic [11:0] a, input logic [7:0] d);
      int n;
      // A halted core issues nothing
      for (n = 0; n < 500 && cpuHalt; n++) @(posedge clk);
      @(posedge clk);
      spmReq  <= 1'b1;
      spmAddr <= a;
      spmData <= d;
      @(posedge clk);
      spmReq  <= 1'b0;
      // Released lines show garbage, never the old value
      spmAddr <= ~a;
      spmData <= ~d;
   endtask : store_program_op

   task automatic lpm(input logic [11:0] a);
      @(posedge clk);
      lpmReq  <= 1'b1;
      lpmAddr <= a;
      @(posedge clk);
      lpmReq  <= 1'b0;
      lpmAddr <= ~a;
   endtask : lpm
endmodule : fsag_cpu_model
`default_nettype wire

//--- verif/fsag_guard_tb.sv
// Self-checking testbench of the flash section access guard
`include "fsag_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fsag_guard_tb;
   import fsag_pkg::*;
   logic        clk, rstn, ce, chipErase, progDone, spmReq, lpmReq;
   logic [1:0]  bootSizeFuse, s_axi_bresp, s_axi_rresp;
   logic [11:0] execAddr, spmAddr, lpmAddr, flashPage_q, pg;
   logic [7:0]  spmData, s_axi_awaddr, s_axi_araddr;
   logic        spmAck_q, spmNack_q, lpmOk_q, lpmDenied_q, cpuHalt_q;
   logic        rwwBusy_q, fetchBlock_q, irqSuppress_q, flashStart_q;
   fsag_op_t    flashOp_q;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [33:0] expQ[$];
   logic [15:0] lfsr;
   int          fails, compares, v;

   fsag_guard i_fsag_guard (.clk, .rstn, .ce, .bootSizeFuse, .chipErase,
      .execAddr, .spmReq, .spmAddr, .spmData, .lpmReq, .lpmAddr, .progDone,
      .spmAck_q, .spmNack_q, .lpmOk_q, .lpmDenied_q, .cpuHalt_q, .rwwBusy_q,
      .fetchBlock_q, .irqSuppress_q, .flashStart_q, .flashOp_q, .flashPage_q,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   fsag_cpu_model i_fsag_cpu_model (.clk, .cpuHalt(cpuHalt_q),
      .rwwBusy(rwwBusy_q), .execAddr, .spmReq, .spmAddr, .spmData, .lpmReq,
      .lpmAddr);

   always #5 clk = ~clk;

   function automatic logic [15:0] nextRand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nextRand

   task automatic test_done();
      $display("Compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   task automatic check(input string w, input logic [33:0] s, e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask : check

   task automatic chk1(input string w, input logic s, e);
      check(w, {33'h0, s}, {33'h0, e});
   endtask : chk1

   task automatic hang();
      fails++;
      $display("ERROR bus wait expected answer seen none");
      test_done();
   endtask : hang

   task automatic cmpNext(input string w, input logic [33:0] s);
      if (expQ.size() == 0) hang();
      else check(w, s, expQ.pop_front());
   endtask : cmpNext

   // Each answer is matched against the oldest note
   always @(posedge clk) begin
      if (spmAck_q | spmNack_q) cmpNext("store", {32'h0, spmNack_q, spmAck_q});
      if (lpmOk_q | lpmDenied_q) cmpNext("load", {32'h0, lpmDenied_q, lpmOk_q});
      if (s_axi_bvalid & s_axi_bready) cmpNext("bresp", {32'h0, s_axi_bresp});
      if (s_axi_rvalid & s_axi_rready) cmpNext("rdata", {s_axi_rresp, s_axi_rdata});
   end

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] r);
      int n;
      expQ.push_back({32'h0, r});
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 40) hang();
   endtask : axiWrite

   task automatic axiRead(input logic [7:0] a, input logic [33:0] e);
      int n;
      expQ.push_back(e);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 40) hang();
   endtask : axiRead

   task automatic cmd(input logic [4:0] c);
      axiWrite(`FSAG_CTRL_OFS, {27'h0, c}, `FSAG_RESP_OK);
   endtask : cmd

   task automatic store(input logic [11:0] a, input logic ok,
                        input logic [7:0] d);
      expQ.push_back({32'h0, !ok, ok});
      i_fsag_cpu_model.store_program_op(a, d);
   endtask : store

   task automatic load(input logic [11:0] a, input logic ok);
      expQ.push_back({32'h0, !ok, ok});
      i_fsag_cpu_model.lpm(a);
   endtask : load

   task automatic done();
      @(posedge clk);
      progDone <= 1'b1;
      @(posedge clk);
      progDone <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : done

   task automatic irqAt(input logic [11:0] a, input logic e);
      i_fsag_cpu_model.goExec(a);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk1("irq gate", irqSuppress_q, e);
   endtask : irqAt

   task automatic lockCase(input logic [3:0] k);
      @(posedge clk);
      chipErase <= 1'b1;
      repeat (4) @(posedge clk);
      chipErase <= 1'b0;
      repeat (4) @(posedge clk);
      axiRead(`FSAG_LOCK_OFS, {30'h0, 4'hF});
      axiWrite(`FSAG_LOCK_OFS, {28'h0, k}, `FSAG_RESP_OK);
      axiRead(`FSAG_LOCK_OFS, {30'h0, k});
      i_fsag_cpu_model.goExec(12'hC80);
      load(12'h100, k[1]);
      i_fsag_cpu_model.goExec(12'h100);
      load(12'hD00, k[3]);
      for (int b = 0; b < 2; b++) begin
         axiWrite(`FSAG_CONF_OFS, b, `FSAG_RESP_OK);
         irqAt(12'h100, !k[1] && b == 1);
         irqAt(12'hC80, !k[3] && b == 0);
      end
      cmd(`FSAG_CMD_WRITE);
      store(12'h200, k[0], lfsr[7:0]);
      if (k[0]) begin
         done();
         cmd(`FSAG_CMD_REEN);
         store(12'h200, 1'b1, 8'h00);
      end
      cmd(`FSAG_CMD_ERASE);
      store(12'hD00, k[2], lfsr[15:8]);
      if (k[2]) done();
   endtask : lockCase

   initial begin
      {clk, rstn, chipErase, progDone, bootSizeFuse} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      ce = 1'b1;
      lfsr = 16'h0008;
      {fails, compares} = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      axiRead(`FSAG_LOCK_OFS, {30'h0, `FSAG_LOCK_RST});
      axiRead(`FSAG_STAT_OFS, {2'h0, 32'h3000});
      axiRead(8'h10, {`FSAG_RESP_ERR, 32'h0});
      axiWrite(8'h14, 32'h0, `FSAG_RESP_ERR);
      i_fsag_cpu_model.goExec(12'h100);
      cmd(`FSAG_CMD_ERASE);
      store(12'h100, 1'b0, 8'h00);
      i_fsag_cpu_model.goExec(12'hC80);
      lfsr = nextRand(lfsr);
      pg = lfsr[11:0] % 12'hC00;
      cmd(`FSAG_CMD_ERASE);
      store(pg, 1'b1, lfsr[15:8]);
      @(negedge clk);
      chk1("start", flashStart_q, 1'b1);
      check("op", {31'h0, flashOp_q}, {31'h0, OP_ERASE});
      check("page", {22'h0, flashPage_q}, {22'h0, pg});
      chk1("busy", rwwBusy_q, 1'b1);
      chk1("halt", cpuHalt_q, 1'b0);
      chk1("fetch", fetchBlock_q, 1'b0);
      load(12'hD00, 1'b1);
      load(pg, 1'b0);
      done();
      chk1("busy", rwwBusy_q, 1'b1);
      cmd(`FSAG_CMD_LOAD);
      store(pg, 1'b1, 8'h5A);
      @(negedge clk);
      chk1("busy", rwwBusy_q, 1'b0);
      cmd(`FSAG_CMD_WRITE);
      store(pg, 1'b1, 8'hA5);
      done();
      // Arm lapses after four edges, so a late store is refused
      cmd(`FSAG_CMD_REEN);
      repeat (6) @(posedge clk);
      store(pg, 1'b0, 8'h00);
      cmd(`FSAG_CMD_REEN);
      store(pg, 1'b1, 8'h00);
      @(negedge clk);
      chk1("busy", rwwBusy_q, 1'b0);
      cmd(`FSAG_CMD_ERASE);
      store(12'hC40, 1'b1, 8'h00);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk1("halt", cpuHalt_q, 1'b1);
      chk1("busy", rwwBusy_q, 1'b0);
      done();
      @(negedge clk);
      chk1("halt", cpuHalt_q, 1'b0);
      cmd(`FSAG_CMD_LOCK);
      store(12'h000, 1'b1, 8'h38);
      axiRead(`FSAG_LOCK_OFS, {30'h0, 4'hE});
      for (v = 0; v < 16; v++) begin
         lfsr = nextRand(lfsr);
         lockCase(v[3:0]);
      end
      bootSizeFuse <= 2'h3;
      repeat (4) @(posedge clk);
      axiRead(`FSAG_STAT_OFS, {2'h0, 32'h3E00});
      i_fsag_cpu_model.goExec(12'hE00);
      cmd(`FSAG_CMD_ERASE);
      store(12'hD00, 1'b0, 8'h00);
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule : fsag_guard_tb
`default_nettype wire
